/* hw/swpg_core_max.v */
// Picks the most active core state out of a packed vector of core states
`timescale 1ns/1ps

module swpg_core_max #(
	parameter CORES = 4,
	parameter SW = 3
) (
	// Packed core states, smaller code means more active
	input wire [CORES*SW-1:0] core_state_i,
	// Shallowest state found
	output wire [SW-1:0] min_state_o
);

wire [SW-1:0] chain [0:CORES];

assign chain[0] = {SW{1'b1}};

// Running minimum across cores
genvar g;
generate
	for (g = 0; g < CORES; g = g + 1) begin : g_cmp
		wire [SW-1:0] cs = core_state_i[g*SW +: SW];
		assign chain[g+1] = (cs < chain[g]) ? cs : chain[g];
	end
endgenerate

assign min_state_o = chain[CORES];

endmodule // swpg_core_max

/* hw/swpg_defs.vh */
// Register offsets, field positions, reset values and timing counts for the sleep/wake gate
`ifndef SWPG_DEFS_VH
`define SWPG_DEFS_VH

// Register byte offsets on the Wishbone bus
`define SWPG_OFF_CTRL 4'h0
`define SWPG_OFF_SLEEP_REQ 4'h4
`define SWPG_OFF_STATUS 4'h8
`define SWPG_OFF_IRQ_STAT 4'hC

// Control register fields
`define SWPG_CTRL_MGMT_IRQ_EN 0
`define SWPG_CTRL_DS_BATT_ONLY 1
`define SWPG_CTRL_DS_EN 2
`define SWPG_CTRL_VID_ALT 3
`define SWPG_CTRL_VID0 4
`define SWPG_CTRL_VID1 5
`define SWPG_CTRL_RESET 8'h00

// Mask register sits in the upper half-word of the interrupt status word
`define SWPG_IRQ_MASK_LSB 16
`define SWPG_IRQ_MASK_RESET 4'h0

// Interrupt event bits
`define SWPG_EV_BATT_LOW 0
`define SWPG_EV_WAKE_BLOCK 1
`define SWPG_EV_AC_CHANGE 2
`define SWPG_EV_PKG_CHANGE 3

// Sleep states, 3-bit codes
`define SWPG_S0 3'h0
`define SWPG_S3 3'h3
`define SWPG_S4 3'h4
`define SWPG_S5 3'h5
`define SWPG_DS4 3'h6
`define SWPG_DS5 3'h7

// Package idle states, 2-bit codes
`define SWPG_PKG_ACTIVE 2'h0
`define SWPG_PKG_C2 2'h1
`define SWPG_PKG_C3 2'h2
`define SWPG_PKG_DEEP 2'h3

// Dwell in each intermediate package idle step, in ns
`define SWPG_PKG_STEP_NS 200
`define SWPG_CLK_NS 10
`define SWPG_PKG_STEP_CYC ((`SWPG_PKG_STEP_NS + `SWPG_CLK_NS - 1) / `SWPG_CLK_NS)

`endif

/* hw/swpg_sync.v */
// Three-stage synchroniser with agreement filter for asynchronous pins
`timescale 1ns/1ps

module swpg_sync #(
	parameter WIDTH = 2,
	parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Pin side
	input wire [WIDTH-1:0] pin_i,
	// Filtered level
	output reg [WIDTH-1:0] level_o
);

reg [WIDTH-1:0] meta;
reg [WIDTH-1:0] stage2;
reg [WIDTH-1:0] stage3;

////////////////////////////////////////////////////////////////////////////////
// First stage only feeds the second; level changes when stages two and three agree
always @(posedge clk_i) begin
	if (rst_i) begin
		meta <= RESET_VAL;
		stage2 <= RESET_VAL;
		stage3 <= RESET_VAL;
		level_o <= RESET_VAL;
	end else begin
		meta <= pin_i;
		stage2 <= meta;
		stage3 <= stage2;
		level_o <= (stage2 & stage3) | ((stage2 | stage3) & level_o);
	end
end

endmodule // swpg_sync

/* hw/swpg_top.v */
// Sleep/wake power gate: battery-low wake blocking, AC deep-sleep policy, VID, package idle
`timescale 1ns/1ps
`include "swpg_defs.vh"

// Summary of operation
// (RULE_01) Low battery blocks every wake from S3/S4/S5 and every deep-sleep exit.
// (RULE_02) Battery-low assertion raises the management interrupt when its enable is set.
// (RULE_03) Deep-sleep entry from S4/S5 can be limited to battery operation.
// (RULE_04) By default both core voltage-ID outputs are driven high.
// (RULE_05) Software never selects C2/C3; they are steps between active and deep idle.
// (RULE_06) Reported core state comes from the most active core.
// (RULE_07) Battery-low pin is active low; unused platforms tie it high.
module swpg_top #(
	parameter CORES = 4,
	parameter CSW = 3,
	parameter [7:0] STEP_CYC = `SWPG_PKG_STEP_CYC
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Platform pins
	input wire ac_power_present_i,
	input wire battery_low_n_i,
	input wire wake_event_i,
	input wire [CORES*CSW-1:0] core_state_i,
	// Outputs
	output reg core_voltage_id_bit0_o,
	output reg core_voltage_id_bit1_o,
	output wire system_management_irq_o,
	output wire irq_o,
	output reg [2:0] sleep_state_o,
	output reg [1:0] package_state_o,
	output reg [CSW-1:0] reported_core_state_o
);

// Package idle state codes
localparam [1:0] PK_ACT = `SWPG_PKG_ACTIVE;
localparam [1:0] PK_C2 = `SWPG_PKG_C2;
localparam [1:0] PK_C3 = `SWPG_PKG_C3;
localparam [1:0] PK_DEEP = `SWPG_PKG_DEEP;

// Register byte address match
function sel_reg;
	input [3:0] adr;
	input [3:0] off;
	begin
		sel_reg = (adr == off);
	end
endfunction

reg [7:0] ctrl;
reg [3:0] irq_stat;
reg [3:0] irq_mask;
reg [2:0] sleep_req;
reg sleep_req_pend;
reg pkg_deep_req;
reg [7:0] step_cnt;
reg batt_low_d;
reg ac_d;
reg [1:0] pkg_d;
reg [3:0] next_irq_stat;
wire [1:0] pins_sync;
wire ac_power_present;
wire battery_low;
wire wake_sync;
wire [CSW-1:0] min_core;
wire wb_req;
wire wb_wr;
wire [3:0] ev;
wire wake_pend;
wire wake_rise;
reg wake_d;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers; battery-low resets to the idle high level
// Wake and battery-low reset to their idle levels; AC resets low, so a present supply logs an AC change after reset
swpg_sync #(
	.WIDTH(2),
	.RESET_VAL(2'b10)
) u_sync (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.pin_i({battery_low_n_i, ac_power_present_i}),
	.level_o(pins_sync)
);

swpg_sync #(
	.WIDTH(1),
	.RESET_VAL(1'b0)
) u_wake_sync (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.pin_i(wake_event_i),
	.level_o(wake_sync)
);

assign ac_power_present = pins_sync[0];
assign battery_low = ~pins_sync[1]; // RULE_07

// Most active core picks the reported state
// Combinational scan, registered below so the output stays a flip-flop
swpg_core_max #(
	.CORES(CORES),
	.SW(CSW)
) u_core_max (
	.core_state_i(core_state_i),
	.min_state_o(min_core)
);

////////////////////////////////////////////////////////////////////////////////
// Wishbone single-cycle slave: ack one cycle after the strobe
// Ack gates the request so one held strobe never counts twice
assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign wb_wr = wb_req & wb_we_i & wb_sel_i[0];

always @(posedge clk_i) begin
	if (rst_i) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h0000_0000;
	end else begin
		wb_ack_o <= wb_req;
		if (wb_req && !wb_we_i) begin
			if (sel_reg(wb_adr_i, `SWPG_OFF_CTRL))
				wb_dat_o <= {24'h00_0000, ctrl};
			else if (sel_reg(wb_adr_i, `SWPG_OFF_SLEEP_REQ))
				wb_dat_o <= {29'h0000_0000, sleep_req};
			else if (sel_reg(wb_adr_i, `SWPG_OFF_STATUS))
				// AC bit 0, battery low bit 1, sleep [4:2], package [7:6], core [13:11]
				wb_dat_o <= {16'h0000, 2'b00, reported_core_state_o, 3'b000,
					package_state_o, 1'b0, sleep_state_o, battery_low, ac_power_present};
			else if (sel_reg(wb_adr_i, `SWPG_OFF_IRQ_STAT))
				wb_dat_o <= {12'h000, irq_mask, 12'h000, irq_stat};
			else
				wb_dat_o <= 32'h0000_0000; // Unmapped reads as zero
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control and mask registers, sleep requests from software
always @(posedge clk_i) begin
	if (rst_i) begin
		ctrl <= `SWPG_CTRL_RESET;
		irq_mask <= `SWPG_IRQ_MASK_RESET;
		sleep_req <= `SWPG_S0;
		sleep_req_pend <= 1'b0;
		pkg_deep_req <= 1'b0;
	end else begin
		sleep_req_pend <= 1'b0;
		if (wb_wr && sel_reg(wb_adr_i, `SWPG_OFF_CTRL))
			ctrl <= wb_dat_i[7:0];
		if (wb_wr && sel_reg(wb_adr_i, `SWPG_OFF_SLEEP_REQ)) begin
			// Bit 8 asks for deep package idle; only active or deep can be requested
			sleep_req <= wb_dat_i[2:0];
			sleep_req_pend <= 1'b1;
			pkg_deep_req <= wb_dat_i[8]; // RULE_05
		end
		// Mask has its own byte lane so status clears can leave it alone
		if (wb_req && wb_we_i && wb_sel_i[2] && sel_reg(wb_adr_i, `SWPG_OFF_IRQ_STAT))
			irq_mask <= wb_dat_i[`SWPG_IRQ_MASK_LSB +: 4];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Sleep state machine with wake blocking and AC-based deep-sleep policy
assign wake_rise = wake_sync & ~wake_d;
assign wake_pend = wake_rise && (sleep_state_o != `SWPG_S0);

always @(posedge clk_i) begin
	if (rst_i) begin
		sleep_state_o <= `SWPG_S0;
		wake_d <= 1'b0;
	end else begin
		wake_d <= wake_sync;
		case (sleep_state_o)
		`SWPG_S0: begin
			// Only S3, S4 and S5 are legal targets; other codes are dropped
			if (sleep_req_pend && (sleep_req == `SWPG_S3 || sleep_req == `SWPG_S4 ||
				sleep_req == `SWPG_S5))
				sleep_state_o <= sleep_req;
		end
		`SWPG_S4, `SWPG_S5: begin
			// Deep entry only when enabled, and optionally only on battery
			if (wake_pend && !battery_low)
				sleep_state_o <= `SWPG_S0; // RULE_01
			else if (ctrl[`SWPG_CTRL_DS_EN] &&
				(!ctrl[`SWPG_CTRL_DS_BATT_ONLY] || !ac_power_present)) // RULE_03
				sleep_state_o <= (sleep_state_o == `SWPG_S4) ? `SWPG_DS4 : `SWPG_DS5;
		end
		`SWPG_S3, `SWPG_DS4, `SWPG_DS5: begin
			if (wake_pend && !battery_low)
				sleep_state_o <= `SWPG_S0; // RULE_01
		end
		default: sleep_state_o <= `SWPG_S0;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Package idle sequencer; C2 and C3 are only passed through on the way
always @(posedge clk_i) begin
	if (rst_i) begin
		package_state_o <= PK_ACT;
		step_cnt <= 8'h00;
	end else begin
		case (package_state_o)
		PK_ACT: begin
			step_cnt <= 8'h00;
			if (pkg_deep_req)
				package_state_o <= PK_C2; // RULE_05
		end
		PK_C2, PK_C3: begin
			// Abort back to active if the request drops mid-way
			// Counter restarts for each step so both steps last equally long
			if (!pkg_deep_req) begin
				package_state_o <= PK_ACT;
				step_cnt <= 8'h00;
			end else if (step_cnt == STEP_CYC - 8'h01) begin
				step_cnt <= 8'h00;
				package_state_o <= (package_state_o == PK_C2) ? PK_C3 : PK_DEEP; // RULE_05
			end else begin
				step_cnt <= step_cnt + 8'h01;
			end
		end
		PK_DEEP: begin
			// Leaving deep idle goes straight to active; no stepping on exit
			if (!pkg_deep_req)
				package_state_o <= PK_ACT;
		end
		default: package_state_o <= PK_ACT;
		endcase
	end
end

// Reported core state follows the shallowest core
always @(posedge clk_i) begin
	if (rst_i)
		reported_core_state_o <= {CSW{1'b0}};
	else
		reported_core_state_o <= min_core; // RULE_06
end

////////////////////////////////////////////////////////////////////////////////
// Voltage-ID outputs: high by default, software values only in alternate mode
// Reset always returns to the default so the regulator never sees a stale setting
always @(posedge clk_i) begin
	if (rst_i) begin
		core_voltage_id_bit0_o <= 1'b1; // RULE_04
		core_voltage_id_bit1_o <= 1'b1; // RULE_04
	end else if (ctrl[`SWPG_CTRL_VID_ALT]) begin
		core_voltage_id_bit0_o <= ctrl[`SWPG_CTRL_VID0];
		core_voltage_id_bit1_o <= ctrl[`SWPG_CTRL_VID1];
	end else begin
		core_voltage_id_bit0_o <= 1'b1; // RULE_04
		core_voltage_id_bit1_o <= 1'b1; // RULE_04
	end
end

////////////////////////////////////////////////////////////////////////////////
// Sticky events; a new event in the clearing cycle wins
// Battery-low is an edge event, so a held low level cannot refill the bit after a clear
assign ev[`SWPG_EV_BATT_LOW] = battery_low & ~batt_low_d;
assign ev[`SWPG_EV_WAKE_BLOCK] = wake_pend & battery_low;
assign ev[`SWPG_EV_AC_CHANGE] = ac_power_present ^ ac_d;
assign ev[`SWPG_EV_PKG_CHANGE] = (package_state_o != pkg_d);

always @* begin
	next_irq_stat = irq_stat;
	if (wb_req && wb_we_i && wb_sel_i[0] && sel_reg(wb_adr_i, `SWPG_OFF_IRQ_STAT))
		next_irq_stat = irq_stat & ~wb_dat_i[3:0];
	next_irq_stat = next_irq_stat | ev;
end

always @(posedge clk_i) begin
	if (rst_i) begin
		irq_stat <= 4'h0;
		batt_low_d <= 1'b0;
		ac_d <= 1'b0;
		pkg_d <= PK_ACT;
	end else begin
		irq_stat <= next_irq_stat;
		batt_low_d <= battery_low;
		ac_d <= ac_power_present;
		pkg_d <= package_state_o;
	end
end

// Level interrupt outputs; the management interrupt bypasses the mask, gated by its own enable
assign irq_o = |(irq_stat & irq_mask);
assign system_management_irq_o = ctrl[`SWPG_CTRL_MGMT_IRQ_EN] &
	irq_stat[`SWPG_EV_BATT_LOW]; // RULE_02

endmodule // swpg_top

/* verification/swpg_platform.sv */
// Battery, AC sense and voltage regulator model at the gate's pins
`timescale 1ns/1ps
module swpg_platform (
	// Clock and regulator VID inputs
	input wire clk_i,
	input wire vid0_i,
	input wire vid1_i,
	// Supply sense and regulator setting
	output reg ac_o,
	output reg batt_low_n_o,
	output wire [1:0] vr_o
);
	// On AC with a healthy battery from time zero
	initial begin
		ac_o = 1'b1;
		batt_low_n_o = 1'b1;
	end
	// Sense lines move just after an edge
	task set_supply(input ac, input low);
		@(posedge clk_i);
		ac_o <= ac;
		batt_low_n_o <= !low;
	endtask
	// Regulator takes both VID bits as its setting
	assign vr_o = {vid1_i, vid0_i};
endmodule // swpg_platform

/* verification/swpg_props.sv */
// Port-level assertions for the sleep/wake power gate
`timescale 1ns/1ps
module swpg_props #(
	parameter CORES = 4,
	parameter CSW = 3
) (
	// Clock, reset and bus
	input wire clk_i,
	input wire rst_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire wb_ack_o,
	// Platform side
	input wire ac_power_present_i,
	input wire battery_low_n_i,
	input wire [CORES*CSW-1:0] core_state_i,
	input wire core_voltage_id_bit0_o,
	input wire core_voltage_id_bit1_o,
	input wire system_management_irq_o,
	input wire [2:0] sleep_state_o,
	input wire [1:0] package_state_o,
	input wire [CSW-1:0] reported_core_state_o
);
	reg [7:0] ctrl;
	reg [CSW-1:0] mn;
	integer k;
	wire deep = sleep_state_o[2:1] == 2'b11;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////
	// Shadow control byte; lags the design by one edge, so checks allow it
	always @(posedge clk_i) begin
		if (rst_i)
			ctrl <= 8'h00;
		else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 4'h0
			&& wb_sel_i[0])
			ctrl <= wb_dat_i[7:0];
	end
	// Most active core by plain scan
	always @* begin
		mn = core_state_i[CSW-1:0];
		for (k = 1; k < CORES; k = k + 1)
			if (core_state_i[k*CSW +: CSW] < mn)
				mn = core_state_i[k*CSW +: CSW];
	end
	////////////////////////////////
	wake_block_a: assert property ((!battery_low_n_i)[*6] ##0 sleep_state_o != 3'h0
		|=> sleep_state_o != 3'h0) else $error("wake while battery low");
	mgmt_irq_a: assert property ($fell(battery_low_n_i)
		##1 (ctrl[0] && !battery_low_n_i)[*7] |-> system_management_irq_o)
		else $error("no management interrupt");
	ac_policy_a: assert property (deep && !$past(deep) |-> ctrl[2]
		&& !(ctrl[1] && ac_power_present_i && $past(ac_power_present_i, 6)))
		else $error("deep sleep against AC policy");
	vid_default_a: assert property (!ctrl[3] && !$past(ctrl[3])
		|-> core_voltage_id_bit0_o && core_voltage_id_bit1_o) else $error("VID not high");
	pkg_order_a: assert property (package_state_o != $past(package_state_o)
		&& package_state_o != 2'h0 |-> package_state_o == $past(package_state_o) + 2'h1)
		else $error("package state skipped");
	core_min_a: assert property (!$past(rst_i)
		|-> reported_core_state_o == $past(mn)) else $error("core state not minimum");
	// Main scenarios reached
	cover property (deep);
	cover property (package_state_o == 2'h3);
	cover property (system_management_irq_o);
endmodule // swpg_props

bind swpg_top swpg_props #(.CORES(CORES), .CSW(CSW)) i_swpg_props (.*);

/* verification/test_sleep_wake_power_gating.sv */
// Self-checking bench for the sleep/wake power gate
`timescale 1ns/1ps
module test_sleep_wake_power_gating;
	reg clk_i = 1'b0;
	reg rst_i = 1'b1;
	reg wb_cyc_i = 1'b0;
	reg wb_stb_i = 1'b0;
	reg wb_we_i = 1'b0;
	reg [3:0] wb_adr_i = 4'h0;
	reg [3:0] wb_sel_i = 4'hF;
	reg [31:0] wb_dat_i = 32'h0;
	reg wake_event_i = 1'b0;
	reg [11:0] core_state_i = 12'h000;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, ac_power_present_i, battery_low_n_i, system_management_irq_o, irq_o;
	wire core_voltage_id_bit0_o, core_voltage_id_bit1_o;
	wire [2:0] sleep_state_o, reported_core_state_o;
	wire [1:0] package_state_o, vr;
	reg [31:0] rd;
	reg [14:0] rows [0:4];
	integer n_errors = 0, comparisons = 0, i, t;
	// Short package steps keep the run brief
	swpg_top #(.STEP_CYC(8'h03)) i_swpg_top (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.ac_power_present_i(ac_power_present_i), .battery_low_n_i(battery_low_n_i),
		.wake_event_i(wake_event_i), .core_state_i(core_state_i),
		.core_voltage_id_bit0_o(core_voltage_id_bit0_o),
		.core_voltage_id_bit1_o(core_voltage_id_bit1_o),
		.system_management_irq_o(system_management_irq_o), .irq_o(irq_o),
		.sleep_state_o(sleep_state_o), .package_state_o(package_state_o),
		.reported_core_state_o(reported_core_state_o));
	swpg_platform i_swpg_platform (.clk_i(clk_i), .vid0_i(core_voltage_id_bit0_o),
		.vid1_i(core_voltage_id_bit1_o), .ac_o(ac_power_present_i),
		.batt_low_n_o(battery_low_n_i), .vr_o(vr));
	always #5 clk_i = ~clk_i;
	////////////////////////////////
	task test_done;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input [79:0] name, input [31:0] exp, input [31:0] got);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			n_errors = n_errors + 1;
			$display("[ERR] %0s expected %h seen %h", name, exp, got);
		end
	endtask
	// One classic cycle; the idle edge first keeps requests apart
	task wb(input w, input [3:0] a, input [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		t = 0;
		do begin
			@(posedge clk_i);
			t = t + 1;
		end while (wb_ack_o !== 1'b1 && t < 20);
		chk("ack", 1, wb_ack_o);
		if (wb_ack_o !== 1'b1)
			test_done;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task wait_st(input [2:0] e);
		t = 0;
		while (sleep_state_o !== e && t < 30) begin
			@(posedge clk_i);
			t = t + 1;
		end
		chk("sleep", e, sleep_state_o);
		if (sleep_state_o !== e)
			test_done;
	endtask
	// Wake pulse long enough to pass the pin filter
	task wake;
		@(posedge clk_i);
		wake_event_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		wake_event_i <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask
	////////////////////////////////
	initial begin
		rows[0] = {3'h7, 3'h7, 3'h7, 3'h7, 3'h7};
		rows[1] = {3'h0, 3'h6, 3'h6, 3'h6, 3'h0};
		rows[2] = {3'h5, 3'h1, 3'h7, 3'h3, 3'h1};
		rows[3] = {3'h4, 3'h4, 3'h6, 3'h2, 3'h2};
		rows[4] = {3'h6, 3'h3, 3'h5, 3'h7, 3'h3};
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		for (i = 0; i < 5; i = i + 1) begin
			@(posedge clk_i);
			core_state_i <= rows[i][14:3];
			repeat (2) @(posedge clk_i);
			chk("core_min", rows[i][2:0], reported_core_state_o);
		end
		// Second reset in mid-run
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("vr", 2'h3, vr);
		wb(0, 4'h0, 0);
		chk("ctrl", 0, rd);
		wb(1, 4'h2, 32'hFFFFFFFF);
		wb(0, 4'h2, 0);
		chk("unmapped", 0, rd);
		wb(0, 4'h8, 0);
		chk("status", 32'h00001801, rd);
		// Alternate VID mode, then back to default
		wb(1, 4'h0, 32'h18);
		repeat (2) @(posedge clk_i);
		chk("vr", 2'h1, vr);
		wb(1, 4'h0, 0);
		repeat (2) @(posedge clk_i);
		chk("vr", 2'h3, vr);
		for (i = 3; i < 6; i = i + 1) begin
			wb(1, 4'h4, i);
			wait_st(i[2:0]);
			wake;
			wait_st(3'h0);
		end
		// Low battery while asleep: interrupt, wake refused
		wb(1, 4'hC, 32'h000F000F);
		wb(1, 4'h0, 32'h1);
		wb(1, 4'h4, 3);
		wait_st(3'h3);
		i_swpg_platform.set_supply(1'b1, 1'b1);
		repeat (10) @(posedge clk_i);
		chk("mgmt_irq", 1, system_management_irq_o);
		wake;
		chk("sleep", 3, sleep_state_o);
		wb(0, 4'hC, 0);
		chk("irq_stat", 32'h000F0003, rd & 32'h000F0003);
		chk("irq", 1, irq_o);
		wb(1, 4'hC, 32'h000F000F);
		repeat (2) @(posedge clk_i);
		chk("irq", 0, irq_o);
		i_swpg_platform.set_supply(1'b1, 1'b0);
		repeat (8) @(posedge clk_i);
		wake;
		wait_st(3'h0);
		// Deep sleep only on battery
		wb(1, 4'h0, 32'h6);
		wb(1, 4'h4, 4);
		repeat (10) @(posedge clk_i);
		chk("sleep", 4, sleep_state_o);
		i_swpg_platform.set_supply(1'b0, 1'b0);
		wait_st(3'h6);
		i_swpg_platform.set_supply(1'b0, 1'b1);
		repeat (8) @(posedge clk_i);
		wake;
		chk("sleep", 6, sleep_state_o);
		i_swpg_platform.set_supply(1'b0, 1'b0);
		repeat (8) @(posedge clk_i);
		wake;
		wait_st(3'h0);
		wb(1, 4'h4, 5);
		wait_st(3'h7);
		wake;
		wait_st(3'h0);
		// Deep sleep allowed on AC when not limited to battery
		i_swpg_platform.set_supply(1'b1, 1'b0);
		repeat (8) @(posedge clk_i);
		wb(1, 4'h0, 32'h4);
		wb(1, 4'h4, 4);
		wait_st(3'h6);
		wake;
		wait_st(3'h0);
		// Deep idle request walks through both steps
		wb(1, 4'h4, 32'h100);
		for (i = 1; i < 4; i = i + 1) begin
			t = 0;
			while (package_state_o !== i[1:0] && t < 20) begin
				@(posedge clk_i);
				t = t + 1;
			end
			chk("pkg", i, package_state_o);
		end
		wb(1, 4'h4, 0);
		repeat (2) @(posedge clk_i);
		chk("pkg", 0, package_state_o);
		wb(0, 4'hC, 0);
		chk("irq_stat", 32'h8, rd & 32'h8);
		test_done;
	end
endmodule // test_sleep_wake_power_gating
